// ==== hdl/pmicr_map.svh ====
`ifndef PMICR_MAP_SVH
`define PMICR_MAP_SVH

// ---------------------------------------------
// register offsets and reset values
// ---------------------------------------------
`define PMICR_ADDR_INT 8'h02
`define PMICR_ADDR_STAT 8'h03
`define PMICR_ADDR_CTRL 8'h04
`define PMICR_INT_RESET 8'h80
`define PMICR_STAT_RESET 8'h00
`define PMICR_CTRL_RESET 8'hb1

// ---------------------------------------------
// interrupt register fields
// ---------------------------------------------
`define PMICR_INT_TOP 7
`define PMICR_INT_MASK_HI 6
`define PMICR_INT_MASK_LO 4
`define PMICR_INT_FLAG_HI 2
`define PMICR_INT_FLAG_LO 0

// ---------------------------------------------
// charger control fields
// ---------------------------------------------
`define PMICR_CTRL_TIMER_HI 7
`define PMICR_CTRL_TIMER_LO 6
`define PMICR_CTRL_TMR_ON 5
`define PMICR_CTRL_NTC 4
`define PMICR_CTRL_CHG_RESET 3
`define PMICR_CTRL_EOC_DIS 2
`define PMICR_CTRL_HOLD 1
`define PMICR_CTRL_CHG_ON 0

// ---------------------------------------------
// timing
// ---------------------------------------------
`define PMICR_CLK_MHZ 250
`define PMICR_SEC_CYCLES (`PMICR_CLK_MHZ * 1000000)
`define PMICR_SEC_PER_HOUR 3600
`define PMICR_FAST_H0 4
`define PMICR_FAST_H1 5
`define PMICR_FAST_H2 6
`define PMICR_FAST_H3 8
`define PMICR_PRECHG_MIN 30
`define PMICR_PRECHG_SEC (`PMICR_PRECHG_MIN * 60)

`endif

// ==== hdl/pmicr_pkg.sv ====
package pmicr_pkg;

  // input vector layout after synchronisation
  typedef enum int
  {
    IN_BUTTON,
    IN_AC,
    IN_USB,
    IN_DIE_HOT,
    IN_LOAD_LOOP,
    IN_TEMP_TIMERS_HOLD,
    IN_TEMP_FAULT,
    IN_CHARGING,
    IN_PRECHG,
    IN_BELOW_TERM,
    IN_COUNT
  } pmicr_in_t;

  typedef struct packed {
    logic [9:0] s1;
    logic [9:0] s2;
    logic [9:0] s3;
    logic [9:0] stable;
    logic int_top;
    logic [2:0] mask;
    logic [2:0] flag;
    logic [7:0] ctrl;
    logic [7:0] rdata;
    logic [27:0] pre;
    logic [14:0] secs;
    logic prechg_d;
    logic chg_tout;
    logic pchg_tout;
    logic term_done;
  } pmicr_state_t;

endpackage

// ==== hdl/pmicr_regs.sv ====
`include "pmicr_map.svh"

module pmicr_regs #(
  parameter int SEC_CYCLES = `PMICR_SEC_CYCLES,
  parameter int PRECHG_SEC = `PMICR_PRECHG_SEC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic irq_out,
  input wire logic button_input,
  input wire logic ac_input_present,
  input wire logic usb_input_present,
  input wire logic die_hot_in,
  input wire logic load_loop_in,
  input wire logic temp_suspend_in,
  input wire logic temp_fault_in,
  input wire logic charging_in,
  input wire logic precharge_phase_in,
  input wire logic below_term_in,
  output logic charger_enable,
  output logic charger_reset_hold,
  output logic thermistor_select,
  output logic [1:0] fast_timer_code
);

  pmicr_pkg::pmicr_state_t q;
  pmicr_pkg::pmicr_state_t n;
  logic [9:0] pins;
  logic [9:0] agree;
  logic [2:0] ev_flags;
  logic rd_int;
  logic run;
  logic charging;
  logic timers_on;
  logic [7:0] status;

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  function automatic logic [14:0] fast_limit(input logic [1:0] code);
    unique case (code)
      2'h0: fast_limit = 15'(`PMICR_FAST_H0 * `PMICR_SEC_PER_HOUR);
      2'h1: fast_limit = 15'(`PMICR_FAST_H1 * `PMICR_SEC_PER_HOUR);
      2'h2: fast_limit = 15'(`PMICR_FAST_H2 * `PMICR_SEC_PER_HOUR);
      2'h3: fast_limit = 15'(`PMICR_FAST_H3 * `PMICR_SEC_PER_HOUR);
    endcase
  endfunction

  assign pins = {below_term_in, precharge_phase_in, charging_in, temp_fault_in, temp_suspend_in,
                 load_loop_in, die_hot_in, usb_input_present, ac_input_present, button_input};

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb
  begin
    n = q;
    // pins pass three stages; a level is accepted once stages two and three agree
    n.s1 = pins;
    n.s2 = q.s1;
    n.s3 = q.s2;
    agree = ~(q.s2 ^ q.s3);
    n.stable = (q.stable & ~agree) | (q.s3 & agree);
    ev_flags = {n.stable[pmicr_pkg::IN_BUTTON] ^ q.stable[pmicr_pkg::IN_BUTTON],
                n.stable[pmicr_pkg::IN_AC] ^ q.stable[pmicr_pkg::IN_AC],
                n.stable[pmicr_pkg::IN_USB] ^ q.stable[pmicr_pkg::IN_USB]};

    // a new event in the clearing cycle survives the read
    rd_int = reg_rd && hit(reg_addr, `PMICR_ADDR_INT);
    n.flag = (rd_int ? 3'h0 : q.flag) | ev_flags;

    if (reg_wr && hit(reg_addr, `PMICR_ADDR_INT))
    begin
      n.int_top = reg_wdata[`PMICR_INT_TOP];
      n.mask = reg_wdata[`PMICR_INT_MASK_HI:`PMICR_INT_MASK_LO];
    end
    if (reg_wr && hit(reg_addr, `PMICR_ADDR_CTRL))
    begin
      n.ctrl = reg_wdata;
    end

    // charger sequencing
    timers_on = q.ctrl[`PMICR_CTRL_TMR_ON];
    run = q.ctrl[`PMICR_CTRL_CHG_ON] && !q.ctrl[`PMICR_CTRL_CHG_RESET]
          && !q.chg_tout && !q.term_done;
    charging = run && q.stable[pmicr_pkg::IN_CHARGING];
    n.prechg_d = q.stable[pmicr_pkg::IN_PRECHG];

    if (q.ctrl[`PMICR_CTRL_CHG_RESET])
    begin
      // reset restarts the algorithm: counters and end-of-charge latches cleared
      n.pre = 28'h0;
      n.secs = 15'h0;
      n.chg_tout = 1'b0;
      n.pchg_tout = 1'b0;
      n.term_done = 1'b0;
    end
    else
    begin
      if (!timers_on)
      begin
        n.pre = 28'h0;
        n.secs = 15'h0;
      end
      else if (q.prechg_d && !q.stable[pmicr_pkg::IN_PRECHG])
      begin
        // fast-charge phase gets a fresh count
        n.pre = 28'h0;
        n.secs = 15'h0;
      end
      else if (charging && !q.ctrl[`PMICR_CTRL_HOLD])
      begin
        if (q.pre == 28'(SEC_CYCLES - 1))
        begin
          n.pre = 28'h0;
          n.secs = q.secs + 15'h1;
        end
        else
        begin
          n.pre = q.pre + 28'h1;
        end
      end

      if (timers_on && charging && q.stable[pmicr_pkg::IN_PRECHG] && q.secs >= 15'(PRECHG_SEC))
      begin
        n.pchg_tout = 1'b1;
        n.chg_tout = 1'b1;
      end
      if (timers_on && charging && q.secs >= fast_limit(q.ctrl[`PMICR_CTRL_TIMER_HI:`PMICR_CTRL_TIMER_LO]))
      begin
        n.chg_tout = 1'b1;
      end
      if (charging && q.stable[pmicr_pkg::IN_BELOW_TERM] && !q.ctrl[`PMICR_CTRL_EOC_DIS])
      begin
        n.term_done = 1'b1;
      end
    end

    status = {q.stable[pmicr_pkg::IN_DIE_HOT],
              q.stable[pmicr_pkg::IN_LOAD_LOOP],
              q.stable[pmicr_pkg::IN_TEMP_TIMERS_HOLD],
              q.term_done,
              charging,
              q.chg_tout,
              q.pchg_tout,
              q.stable[pmicr_pkg::IN_TEMP_FAULT]};

    if (reg_rd)
    begin
      if (hit(reg_addr, `PMICR_ADDR_INT))
      begin
        n.rdata = {q.int_top, q.mask, 1'b0, q.flag};
      end
      else if (hit(reg_addr, `PMICR_ADDR_STAT))
      begin
        n.rdata = status;
      end
      else if (hit(reg_addr, `PMICR_ADDR_CTRL))
      begin
        n.rdata = q.ctrl;
      end
      else
      begin
        n.rdata = 8'h00;
      end
    end
  end

  // ---------------------------------------------
  // state register
  // ---------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.int_top <= 1'(`PMICR_INT_RESET >> `PMICR_INT_TOP);
      q.ctrl <= `PMICR_CTRL_RESET;
    end
    else
    begin
      q <= n;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign reg_rdata = q.rdata;
  assign irq_out = |(q.flag & ~q.mask);
  assign charger_enable = run;
  assign charger_reset_hold = q.ctrl[`PMICR_CTRL_CHG_RESET];
  assign thermistor_select = q.ctrl[`PMICR_CTRL_NTC];
  assign fast_timer_code = q.ctrl[`PMICR_CTRL_TIMER_HI:`PMICR_CTRL_TIMER_LO];

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  button_mask_a: assert property (q.flag[2] && q.mask[2] && ((q.flag[1:0] & ~q.mask[1:0]) == 2'h0) |-> !irq_out)
    else $error("masked button flag drives irq");
  ac_irq_a: assert property (ev_flags[1] && !n.mask[1] |=> irq_out)
    else $error("ac change without irq");
  usb_irq_a: assert property (ev_flags[0] && !n.mask[0] |=> irq_out)
    else $error("usb change without irq");
  button_flag_a: assert property ($changed(q.stable[0]) |-> q.flag[2])
    else $error("button toggle not flagged");
  read_clear_a: assert property (reg_rd && reg_addr == `PMICR_ADDR_INT && ev_flags == 3'h0 |=> q.flag == 3'h0)
    else $error("read did not clear flags");
  reset_hold_a: assert property (q.ctrl[3] |-> !charger_enable ##1 (q.secs == 15'h0 && !q.term_done))
    else $error("charger ran during reset");
  chg_off_a: assert property (!q.ctrl[0] |-> !charger_enable && !status[3])
    else $error("charger on while disabled");
  timers_off_a: assert property (!q.ctrl[5] |=> q.secs == 15'h0)
    else $error("timer ran while disabled");
  timer_hold_a: assert property (q.ctrl[1] && q.ctrl[5] && !q.ctrl[3] && q.prechg_d == q.stable[8] |=> $stable(q.secs))
    else $error("timer moved while held");
  eoc_dis_a: assert property (q.ctrl[2] && !q.term_done |=> !q.term_done)
    else $error("termination with end of charge disabled");

endmodule

// ==== verification/pmic_irq_charger_regs_tb.sv ====
module pmic_irq_charger_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic irq_out;
  logic charger_enable;
  logic charger_reset_hold;
  logic thermistor_select;
  logic [1:0] fast_timer_code;
  logic [2:0] pins = 3'h0;
  logic [3:0] st = 4'h0;
  logic chg_in = 1'b0;
  logic pre_in = 1'b0;
  logic term_in = 1'b0;
  logic [31:0] seed = 32'ha145;
  logic [7:0] rd;
  logic [7:0] v;
  int n_fail = 0;
  int n_checks = 0;
  int k;

  always #2 core_clk = ~core_clk;

  // short second so the precharge limit is 12 cycles
  pmicr_regs #(.SEC_CYCLES(4), .PRECHG_SEC(3)) u_dut (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_out(irq_out),
    .button_input(pins[2]), .ac_input_present(pins[1]), .usb_input_present(pins[0]),
    .die_hot_in(st[3]), .load_loop_in(st[2]), .temp_suspend_in(st[1]), .temp_fault_in(st[0]),
    .charging_in(chg_in), .precharge_phase_in(pre_in), .below_term_in(term_in),
    .charger_enable(charger_enable), .charger_reset_hold(charger_reset_hold),
    .thermistor_select(thermistor_select), .fast_timer_code(fast_timer_code)
  );

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic end_of_test();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask

  // data is registered at the taking edge, settled by the next falling edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  // ---------------------------------------------
  // sequence
  // ---------------------------------------------
  initial
  begin
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    rd_reg(8'h02, rd); chk_byte(rd, 8'h80, "int reset");
    rd_reg(8'h03, rd); chk_byte(rd, 8'h00, "status reset");
    rd_reg(8'h04, rd); chk_byte(rd, 8'hb1, "ctrl reset");
    chk_byte({6'h0, fast_timer_code}, 8'h02, "timer code reset");
    chk_bit(thermistor_select, 1'b1, "ntc reset");
    chk_bit(charger_enable, 1'b1, "enable reset");
    rd_reg(8'h07, rd); chk_byte(rd, 8'h00, "unmapped read");
    wr_reg(8'h03, 8'hff);
    rd_reg(8'h03, rd); chk_byte(rd, 8'h00, "status write ignored");
    $display("test reset done");

    for (int i = 0; i < 10; i++)
    begin
      seed = xs(seed);
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
      wr_reg(8'h04, v);
      rd_reg(8'h04, rd); chk_byte(rd, v, "ctrl readback");
      chk_byte({6'h0, fast_timer_code}, {6'h0, v[7:6]}, "timer code");
      chk_bit(thermistor_select, v[4], "ntc select");
      chk_bit(charger_reset_hold, v[3], "reset hold");
      chk_bit(charger_enable, v[0] & ~v[3], "enable");
    end
    $display("test control done");

    for (int i = 0; i < 3; i++)
      for (int m = 0; m < 2; m++)
      begin
        v = 8'h80;
        v[i + 4] = m[0];
        wr_reg(8'h02, v);
        pins[i] = ~pins[i];
        wait_cyc(6);
        chk_bit(irq_out, ~m[0], "irq on change");
        rd_reg(8'h02, rd); chk_byte(rd, v | (8'h01 << i), "change flag");
        rd_reg(8'h02, rd); chk_byte(rd, v, "flag cleared by read");
        chk_bit(irq_out, 1'b0, "irq released");
      end
    wr_reg(8'h02, 8'hff);
    rd_reg(8'h02, rd); chk_byte(rd, 8'hf0, "flags read only");
    wr_reg(8'h02, 8'h80);
    $display("test interrupt done");

    // timers off so live status can be varied freely
    repeat (8)
    begin
      seed = xs(seed);
      wr_reg(8'h04, {7'h00, seed[5]});
      st = seed[3:0];
      chg_in = seed[4];
      wait_cyc(5);
      rd_reg(8'h03, rd);
      chk_byte(rd, {st[3:1], 1'b0, chg_in & seed[5], 2'b00, st[0]}, "status");
    end
    st = 4'h0;
    chg_in = 1'b1;
    pre_in = 1'b1;
    $display("test status done");

    for (int j = 0; j < 2; j++)
    begin
      wr_reg(8'h04, (j == 0) ? 8'h01 : 8'h23);
      wait_cyc(60);
      chk_bit(charger_enable, 1'b1, "timer off or held");
    end
    wr_reg(8'h04, 8'h21);
    for (k = 0; k < 100 && charger_enable; k++)
      @(negedge core_clk);
    if (k == 100)
    begin
      n_fail++;
      $display("unexpected at %0t: precharge timeout never came", $time);
      end_of_test();
    end
    chk_bit(k >= 8 && k <= 24, 1'b1, "precharge limit length");
    rd_reg(8'h03, rd); chk_byte(rd, 8'h06, "timeout status");
    pre_in = 1'b0;
    wr_reg(8'h04, 8'h29);
    chk_bit(charger_reset_hold, 1'b1, "reset held");
    chk_bit(charger_enable, 1'b0, "held off");
    wr_reg(8'h04, 8'h21);
    wait_cyc(6);
    chk_bit(charger_enable, 1'b1, "restart");
    rd_reg(8'h03, rd); chk_byte(rd, 8'h08, "restart status");
    $display("test timers done");

    term_in = 1'b1;
    wr_reg(8'h04, 8'h25);
    wait_cyc(8);
    chk_bit(charger_enable, 1'b1, "termination skipped");
    wr_reg(8'h04, 8'h21);
    wait_cyc(8);
    chk_bit(charger_enable, 1'b0, "terminated");
    rd_reg(8'h03, rd); chk_byte(rd, 8'h10, "termination status");
    $display("test termination done");
    end_of_test();
  end
endmodule
